// [include/mgmt_defs.svh]
// Offsets, field positions, reset values and timing counts of the management block.
// Assumes a 20 MHz system clock and a two-wire target port on sampled pins.
`ifndef MGMT_DEFS_SVH
`define MGMT_DEFS_SVH
`define CLK_HZ 20000000
`define DEV_ADDR 7'h50
`define OFS_GLOBAL_CTRL 8'h1A
`define OFS_PAGE_SEL 8'h7F
`define OFS_TX_DISABLE 8'h82
`define OFS_TX_SQ_OVR 8'h83
`define OFS_TX_FAULT 8'h87
`define OFS_RX_DISABLE 8'h8A
`define OFS_RX_SQ_OVR 8'h8B
`define OFS_RX_LOS 8'h93
`define OFS_RX_LOS_MASK 8'h9C
`define OFS_EQ_SET0 8'hA2
`define OFS_EQ_SET1 8'hC5
`define EQ_BYTES 8
`define PAGE_CTRL 8'h10
`define PAGE_FLAGS 8'h11
`define BIT_SW_RESET 3
`define BIT_FORCE_LP 4
`define BIT_LP_REQ 6
`define CTRL_RESET 8'h00
`define EQ_RSVD_LO 4'h8
`define EQ_RSVD_HI 4'hA
`define RESET_MIN_US 10
`define RESET_MIN_CYC ((`RESET_MIN_US * (`CLK_HZ / 1000000)) + 1)
`define MGMT_INIT_MS 2000
`define MGMT_INIT_CYC_DEF (`MGMT_INIT_MS * (`CLK_HZ / 1000))
`define SYNC_W 21
`define SYNC_RST 21'h00001F
`endif

// [include/mgmt_pkg.sv]
// Types shared by the management block.
// Assumes the constants header is compiled alongside.
package mgmt_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_AACK = 7'h04,
        ST_WR = 7'h08,
        ST_WACK = 7'h10,
        ST_RD = 7'h20,
        ST_RACK = 7'h40
    } tws_state_t;
endpackage : mgmt_pkg

// [rtl/module_management_control.sv]
// Management and control logic: two-wire target port, paged registers,
// low power, resets, lane disables, latched loss flags and interrupt.
// Assumes all pins are asynchronous to clk_sys_i and the serial clock is slow.
`timescale 1ns/1ns
`include "mgmt_defs.svh"
module module_management_control #(
    parameter int MGMT_INIT_CYC = `MGMT_INIT_CYC_DEF
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic module_select_n_i,
    input wire logic hard_reset_pin_n_i,
    input wire logic low_power_pin_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [7:0] rx_los_i,
    input wire logic [7:0] tx_los_i,
    output logic interrupt_out_n_o,
    output logic low_power_o,
    output logic init_busy_o,
    output logic [3:0] tx_optical_off_o,
    output logic [7:0] rx_output_off_o,
    output logic [7:0] rx_squelch_o,
    output logic [7:0] tx_squelch_o,
    output mgmt_pkg::tws_state_t state_o
);
    import mgmt_pkg::*;

    generate
        if (MGMT_INIT_CYC < 1 || MGMT_INIT_CYC > 32'h7FFFFFFF)
        begin : g_bad
            $error("MGMT_INIT_CYC out of range");
        end
    endgenerate

    function automatic logic [4:0] eq_slot(input logic [7:0] a);
        logic [7:0] d0;
        logic [7:0] d1;
        d0 = a - `OFS_EQ_SET0;
        d1 = a - `OFS_EQ_SET1;
        if (d0 < `EQ_BYTES)
            eq_slot = {2'b10, d0[2:0]};
        else if (d1 < `EQ_BYTES)
            eq_slot = {2'b11, d1[2:0]};
        else
            eq_slot = 5'h00;
    endfunction : eq_slot

    function automatic logic [3:0] eq_keep(input logic [3:0] old_c, input logic [3:0] new_c);
        if (new_c >= `EQ_RSVD_LO && new_c <= `EQ_RSVD_HI)
            eq_keep = old_c;
        else
            eq_keep = new_c;
    endfunction : eq_keep

    logic [`SYNC_W-1:0] sync1_reg;
    logic [`SYNC_W-1:0] sync2_reg;
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            sync1_reg <= `SYNC_RST;
            sync2_reg <= `SYNC_RST;
        end
        else
        begin
            sync1_reg <= {tx_los_i, rx_los_i, low_power_pin_i, hard_reset_pin_n_i,
                module_select_n_i, sda_i, scl_i};
            sync2_reg <= sync1_reg;
        end
    end

    logic scl_s;
    logic sda_s;
    logic desel_s;
    logic pin_rst_n_s;
    logic lp_pin_s;
    logic [7:0] rx_los_s;
    logic [7:0] tx_los_s;
    assign scl_s = sync2_reg[0];
    assign sda_s = sync2_reg[1];
    assign desel_s = sync2_reg[2];
    assign pin_rst_n_s = sync2_reg[3];
    assign lp_pin_s = sync2_reg[4];
    assign rx_los_s = sync2_reg[12:5];
    assign tx_los_s = sync2_reg[20:13];

    // A short glitch on the reset pin is not a reset; only a held low level counts.
    logic [7:0] pin_low_cnt_reg;
    logic sw_rst_reg;
    logic mod_rst;
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i || pin_rst_n_s)
            pin_low_cnt_reg <= 8'h00;
        else if (pin_low_cnt_reg != 8'(`RESET_MIN_CYC))
            pin_low_cnt_reg <= pin_low_cnt_reg + 8'h01;
    end
    assign mod_rst = !nrst_i || sw_rst_reg || (pin_low_cnt_reg == 8'(`RESET_MIN_CYC));

    logic [31:0] init_cnt_reg;
    always_ff @(posedge clk_sys_i)
    begin
        if (mod_rst)
            init_cnt_reg <= 32'(MGMT_INIT_CYC);
        else if (init_cnt_reg != 32'h0)
            init_cnt_reg <= init_cnt_reg - 32'h1;
    end

    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end
    // Edges are found by sampling, which holds while the serial clock stays slow.
    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign bus_start = scl_s && scl_q && sda_q && !sda_s;
    assign bus_stop = scl_s && scl_q && !sda_q && sda_s;

    tws_state_t state_reg;
    logic [7:0] sh_reg;
    logic [7:0] tx_reg;
    logic [3:0] cnt_reg;
    logic rw_reg;
    logic first_reg;
    logic [7:0] ptr_reg;
    logic wr_reg;
    logic [7:0] wr_addr_reg;
    logic [7:0] wr_data_reg;
    logic rd_reg;
    logic [7:0] rd_addr_reg;
    logic [7:0] rd_data;
    logic [7:0] page_reg;

    always_ff @(posedge clk_sys_i)
    begin
        wr_reg <= 1'b0;
        rd_reg <= 1'b0;
        if (mod_rst || desel_s)
        begin
            state_reg <= ST_IDLE;
            sda_oe_o <= 1'b0;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            rd_addr_reg <= 8'h00;
            if (mod_rst)
                ptr_reg <= 8'h00;
        end
        else if (bus_start)
        begin
            state_reg <= ST_ADDR;
            sda_oe_o <= 1'b0;
            cnt_reg <= 4'h0;
        end
        else if (bus_stop)
        begin
            state_reg <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        sh_reg <= {sh_reg[6:0], sda_s};
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    else if (scl_fall && cnt_reg == 4'h8)
                    begin
                        if (sh_reg[7:1] == `DEV_ADDR)
                        begin
                            state_reg <= ST_AACK;
                            sda_oe_o <= 1'b1;
                            rw_reg <= sh_reg[0];
                        end
                        else
                            state_reg <= ST_IDLE;
                    end
                end
                ST_AACK, ST_RACK:
                begin
                    if (scl_rise && state_reg == ST_RACK)
                    begin
                        if (sda_s)
                            state_reg <= ST_IDLE;
                        else
                            cnt_reg <= 4'h1;
                    end
                    else if (scl_fall && (state_reg == ST_AACK || cnt_reg == 4'h1))
                    begin
                        if (rw_reg)
                        begin
                            tx_reg <= rd_data;
                            sda_oe_o <= !rd_data[7];
                            cnt_reg <= 4'h1;
                            state_reg <= ST_RD;
                            rd_reg <= 1'b1;
                            rd_addr_reg <= ptr_reg;
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                        else
                        begin
                            sda_oe_o <= 1'b0;
                            cnt_reg <= 4'h0;
                            first_reg <= 1'b1;
                            state_reg <= ST_WR;
                        end
                    end
                end
                ST_WR:
                begin
                    if (scl_rise)
                    begin
                        sh_reg <= {sh_reg[6:0], sda_s};
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    else if (scl_fall && cnt_reg == 4'h8)
                    begin
                        sda_oe_o <= 1'b1;
                        state_reg <= ST_WACK;
                        first_reg <= 1'b0;
                        if (first_reg)
                            ptr_reg <= sh_reg;
                        else
                        begin
                            wr_reg <= 1'b1;
                            wr_addr_reg <= ptr_reg;
                            wr_data_reg <= sh_reg;
                            ptr_reg <= ptr_reg + 8'h01;
                        end
                    end
                end
                ST_WACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_o <= 1'b0;
                        cnt_reg <= 4'h0;
                        state_reg <= ST_WR;
                    end
                end
                ST_RD:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_reg == 4'h8)
                        begin
                            sda_oe_o <= 1'b0;
                            cnt_reg <= 4'h0;
                            state_reg <= ST_RACK;
                        end
                        else
                        begin
                            sda_oe_o <= !tx_reg[6];
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                end
                default:
                begin
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end

    logic [7:0] ctrl_reg;
    logic [7:0] tx_dis_reg;
    logic [7:0] rx_dis_reg;
    logic [7:0] los_mask_reg;
    logic [7:0] eq_mem [0:15];
    logic [4:0] wr_slot;
    assign wr_slot = eq_slot(wr_addr_reg);

    always_ff @(posedge clk_sys_i)
    begin
        sw_rst_reg <= 1'b0;
        if (mod_rst)
        begin
            ctrl_reg <= `CTRL_RESET;
            page_reg <= 8'h00;
            tx_dis_reg <= 8'h00;
            rx_dis_reg <= 8'h00;
            los_mask_reg <= 8'h00;
        end
        else if (wr_reg)
        begin
            if (wr_addr_reg == `OFS_GLOBAL_CTRL)
            begin
                ctrl_reg <= wr_data_reg & ~(8'h01 << `BIT_SW_RESET);
                sw_rst_reg <= wr_data_reg[`BIT_SW_RESET] && pin_rst_n_s;
            end
            else if (wr_addr_reg == `OFS_PAGE_SEL)
                page_reg <= wr_data_reg;
            else if (page_reg == `PAGE_CTRL && wr_addr_reg == `OFS_TX_DISABLE)
                tx_dis_reg <= wr_data_reg;
            else if (page_reg == `PAGE_CTRL && wr_addr_reg == `OFS_RX_DISABLE)
                rx_dis_reg <= wr_data_reg;
            else if (page_reg == `PAGE_FLAGS && wr_addr_reg == `OFS_RX_LOS_MASK)
                los_mask_reg <= wr_data_reg;
        end
    end
    // Squelch override and fault bytes fall through the decode above untouched.

    // Equalization storage has no reset; software must load it before use.
    always_ff @(posedge clk_sys_i)
    begin
        if (wr_reg && page_reg == `PAGE_CTRL && wr_slot[4])
        begin
            eq_mem[wr_slot[3:0]] <= {eq_keep(eq_mem[wr_slot[3:0]][7:4], wr_data_reg[7:4]),
                eq_keep(eq_mem[wr_slot[3:0]][3:0], wr_data_reg[3:0])};
        end
    end

    logic [7:0] los_flag_reg;
    logic [7:0] fault_flag_reg;
    logic clr_los;
    logic clr_fault;
    assign clr_los = rd_reg && page_reg == `PAGE_FLAGS && rd_addr_reg == `OFS_RX_LOS;
    assign clr_fault = rd_reg && page_reg == `PAGE_FLAGS && rd_addr_reg == `OFS_TX_FAULT;
    always_ff @(posedge clk_sys_i)
    begin
        if (mod_rst)
        begin
            los_flag_reg <= 8'h00;
            fault_flag_reg <= 8'h00;
        end
        else
        begin
            // A loss seen in the clearing cycle survives the clear.
            los_flag_reg <= rx_los_s | (los_flag_reg & ~{8{clr_los}});
            fault_flag_reg <= fault_flag_reg & ~{8{clr_fault}};
        end
    end

    always_comb
    begin
        logic [4:0] rs;
        rs = eq_slot(ptr_reg);
        rd_data = 8'h00;
        if (ptr_reg == `OFS_GLOBAL_CTRL)
            rd_data = ctrl_reg;
        else if (ptr_reg == `OFS_PAGE_SEL)
            rd_data = page_reg;
        else if (page_reg == `PAGE_CTRL && ptr_reg == `OFS_TX_DISABLE)
            rd_data = tx_dis_reg;
        else if (page_reg == `PAGE_CTRL && ptr_reg == `OFS_RX_DISABLE)
            rd_data = rx_dis_reg;
        else if (page_reg == `PAGE_CTRL && rs[4])
            rd_data = eq_mem[rs[3:0]];
        else if (page_reg == `PAGE_FLAGS && ptr_reg == `OFS_TX_FAULT)
            rd_data = fault_flag_reg;
        else if (page_reg == `PAGE_FLAGS && ptr_reg == `OFS_RX_LOS)
            rd_data = los_flag_reg;
        else if (page_reg == `PAGE_FLAGS && ptr_reg == `OFS_RX_LOS_MASK)
            rd_data = los_mask_reg;
    end

    logic [7:0] tx_off_pairs;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_pair
            assign tx_off_pairs[gi] = tx_dis_reg[2*gi] | tx_dis_reg[2*gi+1];
        end
    endgenerate
    assign tx_off_pairs[7:4] = 4'h0;

    always_ff @(posedge clk_sys_i)
    begin
        if (mod_rst)
        begin
            interrupt_out_n_o <= 1'b1;
            low_power_o <= 1'b0;
            init_busy_o <= 1'b1;
            tx_optical_off_o <= 4'h0;
            rx_output_off_o <= 8'h00;
            rx_squelch_o <= 8'h00;
            tx_squelch_o <= 8'h00;
            scl_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_o <= 1'b0;
            state_o <= ST_IDLE;
        end
        else
        begin
            interrupt_out_n_o <= !(|(los_flag_reg & ~los_mask_reg));
            low_power_o <= ctrl_reg[`BIT_FORCE_LP] ||
                (ctrl_reg[`BIT_LP_REQ] && lp_pin_s);
            init_busy_o <= init_cnt_reg > 32'h1;
            tx_optical_off_o <= tx_off_pairs[3:0];
            rx_output_off_o <= rx_dis_reg;
            rx_squelch_o <= rx_los_s;
            tx_squelch_o <= tx_los_s;
            scl_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_o <= 1'b0;
            state_o <= state_reg;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);

    sequence desel_s2;
        desel_s ##1 desel_s;
    endsequence

    low_power_map_a: assert property (!mod_rst && !$past(mod_rst) |->
        low_power_o == ($past(ctrl_reg[`BIT_FORCE_LP]) ||
        ($past(ctrl_reg[`BIT_LP_REQ]) && $past(lp_pin_s))))
        else $error("low power output wrong");
    tx_pair_off_a: assert property (!mod_rst && tx_dis_reg[1] |=> tx_optical_off_o[0] || mod_rst)
        else $error("lane pair not disabled");
    rx_off_a: assert property (!mod_rst && rx_dis_reg[7] |=> rx_output_off_o[7] || mod_rst)
        else $error("receive lane not silenced");
    deselect_release_a: assert property (desel_s2 |-> ##1 !sda_oe_o && state_o == ST_IDLE)
        else $error("bus not released on deselect");
    no_stretch_a: assert property (!scl_oe_o)
        else $error("clock held low");
    int_assert_a: assert property (!mod_rst && |(los_flag_reg & ~los_mask_reg) ##1 !mod_rst
        |-> !interrupt_out_n_o)
        else $error("interrupt not asserted");
    int_release_a: assert property (!mod_rst && (los_flag_reg & ~los_mask_reg) == 8'h00
        ##1 !mod_rst |-> interrupt_out_n_o)
        else $error("interrupt held with no flags");
    flag_set_wins_a: assert property (!mod_rst && rx_los_s[0] |=> los_flag_reg[0] || mod_rst)
        else $error("loss flag lost");
    fault_clear_a: assert property (fault_flag_reg == 8'h00)
        else $error("fault flag set");
    pin_reset_a: assert property (pin_low_cnt_reg == 8'(`RESET_MIN_CYC) |=> init_cnt_reg ==
        32'(MGMT_INIT_CYC))
        else $error("pin reset not taken");
    init_done_a: assert property (!mod_rst && init_cnt_reg != 32'h0 |=>
        init_cnt_reg < $past(init_cnt_reg) || mod_rst)
        else $error("initialization stalled");
endmodule : module_management_control

// [testbench/two_wire_host.sv]
// Behavioural host controller on the two-wire management bus.
// Assumes open-drain wires resolved by the bench with pull-ups to high.
`timescale 1ns/1ns
module two_wire_host (
    input wire logic clk_i,
    input wire logic sda_wire_i,
    output logic scl_drv_o,
    output logic sda_drv_o
);
    initial
    begin
        scl_drv_o = 1'h1;
        sda_drv_o = 1'h1;
    end
    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    // Also serves as a repeated start from a low clock.
    task start_c();
        sda_drv_o <= 1'h1;
        tick(2);
        scl_drv_o <= 1'h1;
        tick(4);
        sda_drv_o <= 1'h0;
        tick(4);
        scl_drv_o <= 1'h0;
        tick(2);
    endtask : start_c
    task stop_c();
        sda_drv_o <= 1'h0;
        tick(2);
        scl_drv_o <= 1'h1;
        tick(4);
        sda_drv_o <= 1'h1;
        tick(8);
    endtask : stop_c
    // Data is sampled late in the high phase, since the target answers some cycles after a fall.
    task bit_io(input logic b, output logic s);
        sda_drv_o <= b;
        tick(2);
        scl_drv_o <= 1'h1;
        tick(4);
        s = sda_wire_i;
        scl_drv_o <= 1'h0;
        tick(2);
    endtask : bit_io
    task send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'h1, s);
        ack = ~s;
    endtask : send
    // Ends every read with a not-acknowledge, a single byte at a time.
    task recv(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'h1, d[i]);
        bit_io(1'h1, s);
    endtask : recv
endmodule : two_wire_host

// [testbench/test_module_management_control.sv]
// Self-checking bench: register traffic over the two-wire port and pin stimulus.
// Assumes the host model, the package and the constants header are compiled first.
`timescale 1ns/1ns
module test_module_management_control;
    import mgmt_pkg::*;
    logic clk_sys_i = 1'h0;
    logic nrst_i = 1'h0;
    logic module_select_n_i = 1'h0;
    logic hard_reset_pin_n_i = 1'h1;
    logic low_power_pin_i = 1'h0;
    logic [7:0] rx_los_i = 8'h00;
    logic [7:0] tx_los_i = 8'h00;
    logic scl_o, scl_oe_o, sda_o, sda_oe_o, interrupt_out_n_o, low_power_o, init_busy_o;
    logic [3:0] tx_optical_off_o;
    logic [7:0] rx_output_off_o, rx_squelch_o, tx_squelch_o, rv, ex;
    tws_state_t state_o;
    logic scl_drv, sda_drv, scl_w, sda_w, ack;
    int n_errors = 0;
    int comparisons = 0;
    // A wire is low when any party pulls it; otherwise the pull-up wins.
    assign scl_w = scl_drv & ~(scl_oe_o & ~scl_o);
    assign sda_w = sda_drv & ~(sda_oe_o & ~sda_o);
    always #25 clk_sys_i = ~clk_sys_i;
    module_management_control #(.MGMT_INIT_CYC(50)) u_module_management_control (
        .clk_sys_i, .nrst_i, .module_select_n_i, .hard_reset_pin_n_i, .low_power_pin_i,
        .scl_i(scl_w), .scl_o, .scl_oe_o, .sda_i(sda_w), .sda_o, .sda_oe_o, .rx_los_i,
        .tx_los_i, .interrupt_out_n_o, .low_power_o, .init_busy_o, .tx_optical_off_o,
        .rx_output_off_o, .rx_squelch_o, .tx_squelch_o, .state_o
    );
    two_wire_host u_two_wire_host (
        .clk_i(clk_sys_i),
        .sda_wire_i(sda_w),
        .scl_drv_o(scl_drv),
        .sda_drv_o(sda_drv)
    );
    task final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task chk1(input logic seen, input logic exp);
        check({7'h00, seen}, {7'h00, exp});
    endtask : chk1
    task tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : tick
    task wr(input logic [7:0] ofs, input logic [7:0] d);
        u_two_wire_host.start_c();
        u_two_wire_host.send(8'hA0, ack);
        chk1(ack, 1'h1);
        u_two_wire_host.send(ofs, ack);
        u_two_wire_host.send(d, ack);
        chk1(ack, 1'h1);
        u_two_wire_host.stop_c();
    endtask : wr
    task rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
        u_two_wire_host.start_c();
        u_two_wire_host.send(8'hA0, ack);
        u_two_wire_host.send(ofs, ack);
        u_two_wire_host.start_c();
        u_two_wire_host.send(8'hA1, ack);
        u_two_wire_host.recv(rv);
        u_two_wire_host.stop_c();
        check(rv, exp);
    endtask : rd_chk
    task probe(input logic [7:0] a);
        u_two_wire_host.start_c();
        u_two_wire_host.send(a, ack);
        u_two_wire_host.stop_c();
    endtask : probe
    // Bounded wait: a stuck initialization is counted and closes the run.
    task wait_ready();
        for (int i = 0; i < 200; i++)
        begin
            tick(1);
            if (init_busy_o === 1'h0)
                return;
        end
        n_errors++;
        $display("ERROR %0t initialization never finished", $time);
        final_report();
    endtask : wait_ready
    initial
    begin
        tick(5);
        nrst_i <= 1'h1;
        wait_ready();
        chk1(interrupt_out_n_o, 1'h1);
        wr(8'h1A, 8'h10);
        tick(4);
        chk1(low_power_o, 1'h1);
        rd_chk(8'h1A, 8'h10);
        wr(8'h1A, 8'h40);
        tick(4);
        chk1(low_power_o, 1'h0);
        low_power_pin_i <= 1'h1;
        tick(6);
        chk1(low_power_o, 1'h1);
        wr(8'h1A, 8'h00);
        tick(4);
        chk1(low_power_o, 1'h0);
        wr(8'h7F, 8'h10);
        wr(8'h82, 8'h05);
        tick(4);
        check({4'h0, tx_optical_off_o}, 8'h03);
        wr(8'h82, 8'h80);
        tick(4);
        check({4'h0, tx_optical_off_o}, 8'h08);
        wr(8'h8A, 8'hA5);
        tick(4);
        check(rx_output_off_o, 8'hA5);
        wr(8'h83, 8'hFF);
        wr(8'h8B, 8'hFF);
        wr(8'h87, 8'hFF);
        rd_chk(8'h82, 8'h80);
        rd_chk(8'h8A, 8'hA5);
        rd_chk(8'h87, 8'h00);
        ex = 8'h00;
        wr(8'hA3, ex);
        for (int c = 0; c < 16; c++)
        begin
            if (c < 8 || c > 10)
                ex = {4'(c), 4'(c)};
            wr(8'hA3, {4'(c), 4'(c)});
            rd_chk(8'hA3, ex);
        end
        wr(8'hC5, 8'h21);
        wr(8'hC5, 8'h9B);
        rd_chk(8'hC5, 8'h2B);
        wr(8'h7F, 8'h11);
        wr(8'h87, 8'hFF);
        rd_chk(8'h87, 8'h00);
        rx_los_i <= 8'h0F;
        tx_los_i <= 8'h3C;
        tick(6);
        check(rx_squelch_o, 8'h0F);
        check(tx_squelch_o, 8'h3C);
        chk1(interrupt_out_n_o, 1'h0);
        rx_los_i <= 8'h00;
        tx_los_i <= 8'h00;
        tick(6);
        chk1(interrupt_out_n_o, 1'h0);
        rd_chk(8'h93, 8'h0F);
        chk1(interrupt_out_n_o, 1'h1);
        rd_chk(8'h93, 8'h00);
        wr(8'h9C, 8'h01);
        rx_los_i <= 8'h01;
        tick(6);
        chk1(interrupt_out_n_o, 1'h1);
        rx_los_i <= 8'h00;
        rd_chk(8'h93, 8'h01);
        wr(8'h9C, 8'h00);
        rx_los_i <= 8'h02;
        tick(6);
        chk1(interrupt_out_n_o, 1'h0);
        rx_los_i <= 8'h00;
        rd_chk(8'h93, 8'h02);
        chk1(interrupt_out_n_o, 1'h1);
        module_select_n_i <= 1'h1;
        tick(4);
        probe(8'hA0);
        chk1(ack, 1'h0);
        module_select_n_i <= 1'h0;
        tick(4);
        probe(8'hA2);
        chk1(ack, 1'h0);
        u_two_wire_host.start_c();
        u_two_wire_host.send(8'hA0, ack);
        u_two_wire_host.send(8'h9C, ack);
        u_two_wire_host.start_c();
        u_two_wire_host.send(8'hA1, ack);
        tick(4);
        chk1(sda_oe_o, 1'h1);
        module_select_n_i <= 1'h1;
        tick(6);
        chk1(sda_oe_o, 1'h0);
        check({1'h0, state_o}, {1'h0, ST_IDLE});
        module_select_n_i <= 1'h0;
        u_two_wire_host.stop_c();
        wr(8'h7F, 8'h10);
        wr(8'h8A, 8'hFF);
        // The software reset takes the port down before the data acknowledge is sampled.
        u_two_wire_host.start_c();
        u_two_wire_host.send(8'hA0, ack);
        chk1(ack, 1'h1);
        u_two_wire_host.send(8'h1A, ack);
        u_two_wire_host.send(8'h08, ack);
        chk1(ack, 1'h0);
        u_two_wire_host.stop_c();
        tick(2);
        chk1(init_busy_o, 1'h1);
        wait_ready();
        check(rx_output_off_o, 8'h00);
        rd_chk(8'h1A, 8'h00);
        wr(8'h7F, 8'h10);
        wr(8'h8A, 8'h3C);
        hard_reset_pin_n_i <= 1'h0;
        tick(210);
        chk1(init_busy_o, 1'h1);
        check(rx_output_off_o, 8'h00);
        hard_reset_pin_n_i <= 1'h1;
        wait_ready();
        chk1(interrupt_out_n_o, 1'h1);
        final_report();
    end
endmodule : test_module_management_control
